// ==== pkg/ccu_map.svh ====
/*
 constants of the control unit: timing, serial lengths, order codes.
 assumes a 50 mhz clock and inclusion by the package, the assertions and the bench.
*/
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH
`define CLK_PERIOD_NS   20
`define MINOR_CYCLE_NS  5000
`define MINOR_CYCLES    (`MINOR_CYCLE_NS / `CLK_PERIOD_NS)
`define ADDR_W          12
`define HALF_W          6
`define PC_SER_LAST     4'h0_00b
`define ADDR_SER_LAST   4'h0_005
`define DIV_STEPS       5'h0_015
`define MPY_STEPS       5'h0_00a
`define PC_RESET        12'h0_000
`define OP_NOP          5'h0_000
`define OP_ADD          5'h0_001
`define OP_SUB          5'h0_002
`define OP_CLA          5'h0_003
`define OP_CLEAR_AND_ADD_MAGNITUDE_OP         5'h0_004
`define OP_MPY          5'h0_005
`define OP_DIV          5'h0_006
`define OP_SHR          5'h0_007
`define OP_RIGHT_SHIFT_ALT_OP         5'h0_008
`define OP_SHL          5'h0_009
`define OP_JMP          5'h0_00a
`define OP_JMPC         5'h0_00b
`define OP_TIM          5'h0_00c
`define OP_ANALOG_INPUT_SELECT_OP         5'h0_00d
`define OP_ANALOG_OUTPUT_OP         5'h0_00e
`define OP_DISCRETE_OUTPUT_OP         5'h0_00f
`define OP_TAU          5'h0_010
`define OP_INDEX_LOAD_RELATIVE_OP         5'h0_011
`define OP_TAN          5'h0_012
`endif

// ==== pkg/ccu_pkg.sv ====
/*
 types of the control unit: sequencer states, dispatcher bundle,
 instruction and conditioning bundles. assumes ccu_map.svh.
*/
`include "ccu_map.svh"
package ccu_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ADDR   = 2'b01,
        ST_EXEC   = 2'b11,
        ST_FINISH = 2'b10
    } fsm_e;

    typedef struct packed {
        logic g_to_operand_line;
        logic memory_operand_gate_line;
        logic operand_clear_line;
        logic operand_to_adder_line;
        logic doubled_operand_line;
        logic left_shift_line;
        logic accumulator_clear_line;
        logic double_right_shift_line;
        logic complement_line;
        logic subtract_mode_line;
    } dispatch_s;

    typedef struct packed {
        logic        relative;
        logic [4:0]  order;
        logic [11:0] addr;
    } instr_s;

    typedef struct packed {
        logic        g_operand;
        logic        operand_sign;
        logic        g_sign;
        logic        g_sign_load;
        logic        b_gt_a;
        logic        overflow_trunc;
        logic        div_subtract;
        logic        transfer_taken;
        logic [19:0] multiplier;
    } cond_s;
endpackage : ccu_pkg

// ==== hdl/serial_computer_control_unit.sv ====
/*
 control unit of a serial-parallel computer: order decode, dispatcher
 pulses, sign logic, program address, operand and relative addressing.
 assumes datapath inputs on clk_i and one instruction at a time.
*/
// Functional notes
// [RULE1] operand-to-adder pulse for add or subtract
// [RULE2] multiply odd bits, divide twenty-one pulses
// [RULE3] doubled operand pulse per even multiplier bit
// [RULE4] left shift one place; with each divide step
// [RULE5] odd right shift: left one, then twos
// [RULE6] clear accumulator for clear-add, shift right, divide
// [RULE7] double right shift only shift right, multiply
// [RULE8] complement after true subtraction, larger subtrahend
// [RULE9] complement after truncated overflow
// [RULE10] never complement during divide
// [RULE11] subtract mode for true subtraction, divide steps
// [RULE12] decode five order bits to one-hot lines
// [RULE13] hold operand, g, accumulator signs; derive new
// [RULE14] twelve-bit program address increments or loads
// [RULE15] increment serially lsb first, write back parallel
// [RULE16] operand address register supplies addresses, counts
// [RULE17] operand address from serializer or relative register
// [RULE18] two serial adders with carry form relative
// [RULE19] relative register two six-bit loops, next instruction
// [RULE20] serializer splits even and odd address bits
// [RULE21] index loads from transfer, relative or serializer
// [RULE22] memory operand gate for non-g operands
// [RULE23] operand clear before loading operand register
// [RULE24] one arithmetic step per five microsecond cycle
// [RULE25] every dispatcher line is a one-clock pulse
// [RULE26] relative address ready before next instruction
// [RULE27] no taken transfer: take incremented address
module serial_computer_control_unit
    import ccu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        instr_valid_i,
    input  wire instr_s      instr_i,
    input  wire cond_s       cond_i,
    input  wire logic [11:0] transfer_i,
    output logic             instr_ready_o,
    output dispatch_s        dispatch_o,
    output logic [31:0]      order_line_o,
    output logic [11:0]      pc_o,
    output logic [11:0]      operand_addr_o,
    output logic [11:0]      rel_addr_o,
    output logic             acc_sign_o,
    output logic             md_sign_o,
    output logic             g_sign_o
);
    localparam logic [7:0] MINOR_LAST = 8'(`MINOR_CYCLES - 1);

    typedef struct packed {
        fsm_e        fsm;
        logic [4:0]  order;
        logic        relative;
        logic [7:0]  tick;
        logic [4:0]  step;
        logic [4:0]  last;
        logic [3:0]  bit_cnt;
        logic [5:0]  ser_even;
        logic [5:0]  ser_odd;
        logic [5:0]  idx_even;
        logic [5:0]  idx_odd;
        logic [5:0]  rel_even;
        logic [5:0]  rel_odd;
        logic        add_carry;
        logic [11:0] pc;
        logic [11:0] pc_shift;
        logic        pc_carry;
        logic [11:0] oar;
        logic        md_sign;
        logic        g_sign;
        logic        acc_sign;
        logic        true_sub;
        logic        b_gt_a;
        dispatch_s   disp;
        logic [31:0] order_line;
    } ctl_s;

    ctl_s s;
    ctl_s next_s;

    function automatic logic [11:0] merge(input logic [5:0] ev,
                                          input logic [5:0] od);
        logic [11:0] r;
        r = '0;
        for (int i = 0; i < 6; i++)
        begin
            r[2*i]   = ev[i];
            r[2*i+1] = od[i];
        end
        return r;
    endfunction : merge

    function automatic logic [11:0] split(input logic [11:0] a);
        logic [11:0] r;
        r = '0;
        for (int i = 0; i < 6; i++)
        begin
            r[i]   = a[2*i];
            r[i+6] = a[2*i+1];
        end
        return r;
    endfunction : split

    function automatic logic maj(input logic a,
                                 input logic b,
                                 input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : maj

    logic [4:0]  cnt;
    logic [11:0] sp;
    logic        se;
    logic        ce;
    logic        so;
    logic        bsign;

    always_comb
    begin
        next_s = s;
        next_s.disp = '0;
        next_s.order_line = '0;
        cnt = s.oar[4:0];
        sp = '0;
        se = 1'b0;
        ce = 1'b0;
        so = 1'b0;
        bsign = (s.order == `OP_SUB) ? ~s.md_sign : s.md_sign;
        if (cond_i.g_sign_load)
        begin
            next_s.g_sign = cond_i.operand_sign;
        end
        case (s.fsm)
            ST_IDLE:
            begin
                if (instr_valid_i)
                begin
                    next_s.order = instr_i.order;
                    next_s.relative = instr_i.relative;
                    next_s.order_line = 32'h0000_0001 << instr_i.order; // RULE12
                    sp = split(instr_i.addr); // RULE20
                    next_s.ser_even = sp[5:0];
                    next_s.ser_odd = sp[11:6];
                    next_s.pc_shift = s.pc;
                    next_s.pc_carry = 1'b1;
                    next_s.add_carry = 1'b0;
                    next_s.bit_cnt = '0;
                    next_s.fsm = ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                if (s.bit_cnt == 4'h0_000)
                begin
                    next_s.oar = s.relative ? merge(s.rel_even, s.rel_odd)
                                            : merge(s.ser_even, s.ser_odd); // RULE17 RULE16
                end
                next_s.pc_shift = {s.pc_shift[0] ^ s.pc_carry,
                                   s.pc_shift[11:1]}; // RULE15
                next_s.pc_carry = s.pc_shift[0] & s.pc_carry;
                if (s.bit_cnt <= `ADDR_SER_LAST)
                begin
                    se = s.ser_even[0] ^ s.idx_even[0] ^ s.add_carry; // RULE18
                    ce = maj(s.ser_even[0], s.idx_even[0], s.add_carry);
                    so = s.ser_odd[0] ^ s.idx_odd[0] ^ ce;
                    next_s.add_carry = maj(s.ser_odd[0], s.idx_odd[0], ce);
                    next_s.rel_even = {se, s.rel_even[5:1]}; // RULE19
                    next_s.rel_odd = {so, s.rel_odd[5:1]};
                    next_s.ser_even = {s.ser_even[0], s.ser_even[5:1]};
                    next_s.ser_odd = {s.ser_odd[0], s.ser_odd[5:1]};
                    next_s.idx_even = {s.idx_even[0], s.idx_even[5:1]};
                    next_s.idx_odd = {s.idx_odd[0], s.idx_odd[5:1]};
                end
                next_s.bit_cnt = s.bit_cnt + 4'h0_001;
                if (s.bit_cnt == `PC_SER_LAST)
                begin
                    next_s.fsm = ST_EXEC; // RULE26
                    next_s.step = '0;
                    next_s.tick = '0;
                    case (s.order)
                        `OP_ADD, `OP_SUB: next_s.last = 5'h0_002;
                        `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP: next_s.last = 5'h0_001;
                        `OP_MPY: next_s.last = `MPY_STEPS;
                        `OP_DIV: next_s.last = `DIV_STEPS;
                        `OP_SHR, `OP_RIGHT_SHIFT_ALT_OP: next_s.last = 5'(({1'b0, cnt}
                                               + 6'h0_001) >> 1);
                        `OP_SHL: next_s.last = cnt;
                        default: next_s.last = '0;
                    endcase
                end
            end
            ST_EXEC:
            begin
                if (s.tick == 8'h0_000) // RULE25 RULE24
                begin
                    if (s.step == 5'h0_000)
                    begin
                        case (s.order)
                            `OP_ADD, `OP_SUB, `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP, `OP_MPY,
                            `OP_DIV:
                            begin
                                next_s.disp.operand_clear_line = 1'b1; // RULE23
                                next_s.disp.g_to_operand_line = cond_i.g_operand;
                                next_s.disp.memory_operand_gate_line =
                                    ~cond_i.g_operand; // RULE22
                                next_s.md_sign = cond_i.g_operand ? s.g_sign
                                                 : cond_i.operand_sign; // RULE13
                            end
                            default:
                            begin
                            end
                        endcase
                        case (s.order)
                            `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP, `OP_DIV:
                                next_s.disp.accumulator_clear_line = 1'b1; // RULE6
                            `OP_SHR, `OP_RIGHT_SHIFT_ALT_OP:
                            begin
                                next_s.disp.accumulator_clear_line = 1'b1; // RULE6
                                next_s.disp.left_shift_line = cnt[0]; // RULE5
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                    else
                    begin
                        case (s.order)
                            `OP_ADD, `OP_SUB:
                            begin
                                if (s.step == 5'h0_001)
                                begin
                                    next_s.true_sub = (s.order == `OP_ADD)
                                        ^ (s.md_sign == s.acc_sign);
                                    next_s.disp.operand_to_adder_line = 1'b1; // RULE1
                                    next_s.disp.subtract_mode_line =
                                        (s.order == `OP_ADD)
                                        ^ (s.md_sign == s.acc_sign); // RULE11
                                end
                                else
                                begin
                                    next_s.b_gt_a = s.true_sub & cond_i.b_gt_a;
                                    next_s.disp.complement_line =
                                        (s.true_sub & cond_i.b_gt_a)
                                        | cond_i.overflow_trunc; // RULE8 RULE9
                                end
                            end
                            `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP:
                                next_s.disp.operand_to_adder_line = 1'b1; // RULE1
                            `OP_MPY:
                            begin
                                next_s.disp.operand_to_adder_line =
                                    cond_i.multiplier[2*(s.step-5'h0_001)+1]; // RULE2
                                next_s.disp.doubled_operand_line =
                                    cond_i.multiplier[2*(s.step-5'h0_001)]; // RULE3
                                next_s.disp.double_right_shift_line = 1'b1; // RULE7
                            end
                            `OP_DIV:
                            begin
                                next_s.disp.operand_to_adder_line = 1'b1; // RULE2
                                next_s.disp.subtract_mode_line =
                                    cond_i.div_subtract; // RULE11 RULE10
                                next_s.disp.left_shift_line = 1'b1; // RULE4
                            end
                            `OP_SHR, `OP_RIGHT_SHIFT_ALT_OP:
                                next_s.disp.double_right_shift_line = 1'b1; // RULE7 RULE5
                            `OP_SHL:
                                next_s.disp.left_shift_line = 1'b1; // RULE4
                            default:
                            begin
                            end
                        endcase
                    end
                end
                if (s.tick == MINOR_LAST)
                begin
                    next_s.tick = '0;
                    next_s.step = s.step + 5'h0_001;
                    if (s.step >= s.last)
                    begin
                        next_s.fsm = ST_FINISH;
                    end
                end
                else
                begin
                    next_s.tick = s.tick + 8'h0_001;
                end
            end
            ST_FINISH:
            begin
                if ((s.order == `OP_JMP) ||
                    ((s.order == `OP_JMPC) && cond_i.transfer_taken))
                begin
                    next_s.pc = s.oar; // RULE14
                end
                else
                begin
                    next_s.pc = s.pc_shift; // RULE27 RULE14
                end
                case (s.order)
                    `OP_TAU: sp = split(transfer_i); // RULE21
                    `OP_INDEX_LOAD_RELATIVE_OP: sp = {s.rel_odd, s.rel_even}; // RULE21
                    `OP_TAN: sp = {s.ser_odd, s.ser_even}; // RULE21
                    default: sp = {s.idx_odd, s.idx_even};
                endcase
                next_s.idx_even = sp[5:0];
                next_s.idx_odd = sp[11:6];
                case (s.order)
                    `OP_ADD, `OP_SUB:
                        next_s.acc_sign = s.b_gt_a ? bsign : s.acc_sign; // RULE13
                    `OP_CLA: next_s.acc_sign = s.md_sign;
                    `OP_CLEAR_AND_ADD_MAGNITUDE_OP: next_s.acc_sign = 1'b0;
                    `OP_MPY, `OP_DIV:
                        next_s.acc_sign = s.acc_sign ^ s.md_sign;
                    default: next_s.acc_sign = s.acc_sign;
                endcase
                next_s.fsm = ST_IDLE;
            end
            default: next_s.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s <= '0;
            s.fsm <= ST_IDLE;
            s.pc <= `PC_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign instr_ready_o = (s.fsm == ST_IDLE);
    assign dispatch_o = s.disp;
    assign order_line_o = s.order_line;
    assign pc_o = s.pc;
    assign operand_addr_o = s.oar;
    assign rel_addr_o = merge(s.rel_even, s.rel_odd);
    assign acc_sign_o = s.acc_sign;
    assign md_sign_o = s.md_sign;
    assign g_sign_o = s.g_sign;
endmodule : serial_computer_control_unit

// ==== testbench/arith_datapath_model.sv ====
/*
 datapath stand-in: counts dispatcher pulses per line for each order
 and keeps the order line last seen.
 assumes dispatcher and order lines registered on clk_i.
*/
module arith_datapath_model
    import ccu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire dispatch_s   dispatch_i,
    input  wire logic [31:0] order_line_i,
    output logic [9:0][7:0]  cnt_o,
    output logic [31:0]      last_order_o
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_o        <= '0;
            last_order_o <= '0;
        end
        else if (order_line_i != 32'h0000_0000)
        begin
            cnt_o        <= '0;
            last_order_o <= order_line_i;
        end
        else
            for (int i = 0; i < 10; i++)
                cnt_o[i] <= cnt_o[i] + 8'(dispatch_i[i]);
    end
endmodule : arith_datapath_model

// ==== testbench/serial_computer_control_unit_asserts.sv ====
/*
 port assertions of the control unit, bound to every instance.
 assumes one clock domain and the order codes of ccu_map.svh.
*/
`include "ccu_map.svh"
module serial_computer_control_unit_asserts
    import ccu_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        instr_valid_i,
    input wire instr_s      instr_i,
    input wire cond_s       cond_i,
    input wire logic [11:0] transfer_i,
    input wire logic        instr_ready_o,
    input wire dispatch_s   dispatch_o,
    input wire logic [31:0] order_line_o,
    input wire logic [11:0] pc_o,
    input wire logic [11:0] operand_addr_o,
    input wire logic [11:0] rel_addr_o,
    input wire logic        acc_sign_o,
    input wire logic        md_sign_o,
    input wire logic        g_sign_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    logic [4:0]  cur_order;
    logic [11:0] pc_take;
    logic [11:0] addr_take;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur_order <= '0;
            pc_take   <= '0;
            addr_take <= '0;
        end
        else if (instr_valid_i && instr_ready_o)
        begin
            cur_order <= instr_i.order;
            pc_take   <= pc_o;
            addr_take <= instr_i.addr;
        end
    end

    sequence s_take;
        instr_valid_i && instr_ready_o;
    endsequence
    sequence s_done;
        $rose(instr_ready_o);
    endsequence

    a_pulse_single: assert property (dispatch_o != '0 |=> dispatch_o == '0)
        else $error("dispatcher line high two cycles");
    a_order_decode: assert property (s_take |=> order_line_o ==
        32'h0000_0001 << $past(instr_i.order) ##1 order_line_o == '0)
        else $error("order line not one pulse of the taken order");
    a_div_no_compl: assert property (cur_order == `OP_DIV |->
        !dispatch_o.complement_line) else $error("complement during divide");
    a_doubled_mpy: assert property (dispatch_o.doubled_operand_line |->
        cur_order == `OP_MPY) else $error("doubled operand outside multiply");
    a_drs_only: assert property (dispatch_o.double_right_shift_line |->
        cur_order inside {`OP_SHR, `OP_RIGHT_SHIFT_ALT_OP, `OP_MPY})
        else $error("double right shift in wrong order");
    a_div_shift: assert property (dispatch_o.left_shift_line &&
        cur_order == `OP_DIV |-> dispatch_o.operand_to_adder_line)
        else $error("divide shift without adder gate");
    a_add_step: assert property (dispatch_o.operand_clear_line &&
        cur_order inside {`OP_ADD, `OP_SUB} |->
        ##250 dispatch_o.operand_to_adder_line)
        else $error("add step not one minor cycle later");
    a_div_clear: assert property (s_take ##0 instr_i.order == `OP_DIV |->
        ##[1:20] dispatch_o.operand_clear_line &&
        dispatch_o.accumulator_clear_line) else $error("divide without clears");
    a_pc_next: assert property (s_done ##0
        !(cur_order inside {`OP_JMP, `OP_JMPC}) |-> pc_o == pc_take + 12'h001)
        else $error("program address not incremented");
    a_oar_direct: assert property (s_take ##0 !instr_i.relative |->
        ##[1:12] operand_addr_o == addr_take)
        else $error("operand address not loaded from field");
    a_idle_hold: assert property (instr_ready_o && !instr_valid_i |=>
        $stable(pc_o) && $stable(rel_addr_o))
        else $error("address registers move while idle");
endmodule : serial_computer_control_unit_asserts

bind serial_computer_control_unit serial_computer_control_unit_asserts
    i_serial_computer_control_unit_asserts (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .cond_i(cond_i),
    .transfer_i(transfer_i), .instr_ready_o(instr_ready_o),
    .dispatch_o(dispatch_o), .order_line_o(order_line_o), .pc_o(pc_o),
    .operand_addr_o(operand_addr_o), .rel_addr_o(rel_addr_o),
    .acc_sign_o(acc_sign_o), .md_sign_o(md_sign_o), .g_sign_o(g_sign_o));

// ==== testbench/serial_computer_control_unit_test.sv ====
/*
 self-checking bench: random orders, expected pulses and addresses.
 assumes the datapath model and a 50 mhz clock.
*/
`include "ccu_map.svh"
module serial_computer_control_unit_test;
    import ccu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [4:0]  ord;
        logic [11:0] pc;
        logic [11:0] oar;
        logic [11:0] rel;
        logic        md;
        logic        sg;
        logic        gs;
        int          cn [10];
    } note_s;

    logic clk_i = 1'b0, arst_n_i, instr_valid_i, instr_ready_o;
    logic acc_sign_o, rdy_prev = 1'b1, acc = 1'b0;
    logic md_sign_o, g_sign_o, md = 1'b0, gs = 1'b0;
    instr_s instr_i;
    cond_s cond_i;
    dispatch_s dispatch_o;
    logic [11:0] transfer_i, pc_o, operand_addr_o, rel_addr_o;
    logic [11:0] pc = '0, rel = '0, idx = '0;
    logic [31:0] order_line_o, last_order;
    logic [9:0][7:0] cnt;
    logic [4:0] tbl [6] = '{`OP_JMP, `OP_JMPC, `OP_TAU, `OP_INDEX_LOAD_RELATIVE_OP, `OP_TAN,
                            `OP_SHL};
    note_s q [$];
    note_s mn;
    int num_errors = 0, checks = 0;

    always #10 clk_i = ~clk_i;

    serial_computer_control_unit i_serial_computer_control_unit (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .cond_i(cond_i), .transfer_i(transfer_i),
        .instr_ready_o(instr_ready_o), .dispatch_o(dispatch_o),
        .order_line_o(order_line_o), .pc_o(pc_o),
        .operand_addr_o(operand_addr_o), .rel_addr_o(rel_addr_o),
        .acc_sign_o(acc_sign_o), .md_sign_o(md_sign_o), .g_sign_o(g_sign_o));

    arith_datapath_model i_arith_datapath_model (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .dispatch_i(dispatch_o),
        .order_line_i(order_line_o), .cnt_o(cnt), .last_order_o(last_order));

    task automatic final_report;
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic issue(input logic [4:0] o);
        note_s  n;
        instr_s ins;
        cond_s  c;
        logic [11:0] t;
        logic [4:0]  sc;
        logic        ts;
        int          gi;
        int          k;
        ins = 18'($urandom);
        c = 28'($urandom);
        t = 12'($urandom);
        ins.order = o;
        if (o < `OP_CLA)
            c.g_operand = 1'b0;
        if (c.g_sign_load)
            gs = c.operand_sign;
        n.cn = '{default: 0};
        n.ord = o;
        n.oar = ins.relative ? rel : ins.addr;
        rel = ins.addr + idx;
        n.rel = rel;
        sc = n.oar[4:0];
        gi = c.g_operand ? 9 : 8;
        ts = (o == `OP_ADD) ? (c.operand_sign != acc) : (c.operand_sign == acc);
        if (o inside {`OP_ADD, `OP_SUB, `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP, `OP_MPY, `OP_DIV})
        begin
            n.cn[7] = 1;
            n.cn[gi] = 1;
            md = c.g_operand ? gs : c.operand_sign;
        end
        case (o)
            `OP_ADD, `OP_SUB:
            begin
                n.cn[6] = 1;
                n.cn[0] = ts;
                n.cn[1] = (ts && c.b_gt_a) || c.overflow_trunc;
                if (ts && c.b_gt_a)
                    acc = c.operand_sign ^ (o == `OP_SUB);
            end
            `OP_CLA, `OP_CLEAR_AND_ADD_MAGNITUDE_OP:
            begin
                n.cn[3] = 1;
                n.cn[6] = 1;
                acc = (o == `OP_CLA) && md;
            end
            `OP_MPY:
            begin
                n.cn[2] = 10;
                acc = acc ^ md;
                for (k = 1; k <= 10; k++)
                begin
                    n.cn[6] += c.multiplier[2*k-1];
                    n.cn[5] += c.multiplier[2*k-2];
                end
            end
            `OP_DIV:
            begin
                n.cn[3] = 1;
                n.cn[6] = 21;
                acc = acc ^ md;
                n.cn[4] = 21;
                n.cn[0] = c.div_subtract ? 21 : 0;
            end
            `OP_SHR, `OP_RIGHT_SHIFT_ALT_OP:
            begin
                n.cn[3] = 1;
                n.cn[4] = sc[0];
                n.cn[2] = (sc + 1) / 2;
            end
            `OP_SHL: n.cn[4] = sc;
            default: ;
        endcase
        n.sg = acc;
        n.md = md;
        n.gs = gs;
        if (o == `OP_JMP || (o == `OP_JMPC && c.transfer_taken))
            pc = n.oar;
        else
            pc = pc + 12'h001;
        n.pc = pc;
        if (o == `OP_TAU)
            idx = t;
        else if (o == `OP_INDEX_LOAD_RELATIVE_OP)
            idx = rel;
        else if (o == `OP_TAN)
            idx = ins.addr;
        @(posedge clk_i);
        #1;
        instr_valid_i = 1'b1;
        instr_i = ins;
        k = 0;
        while (instr_ready_o !== 1'b1 && k < 9000)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k >= 9000)
        begin
            num_errors++;
            final_report();
        end
        @(posedge clk_i);
        q.push_back(n);
        #1;
        instr_valid_i = 1'b0;
        cond_i = c;
        transfer_i = t;
    endtask : issue

    always @(negedge clk_i)
    begin
        if (instr_ready_o === 1'b1 && rdy_prev === 1'b0 && q.size() > 0)
        begin
            mn = q.pop_front();
            chk("order line", 32'h0000_0001 << mn.ord, last_order);
            chk("program address", 32'(mn.pc), 32'(pc_o));
            chk("operand address", 32'(mn.oar), 32'(operand_addr_o));
            chk("relative address", 32'(mn.rel), 32'(rel_addr_o));
            chk("accumulator sign", 32'(mn.sg), 32'(acc_sign_o));
            chk("operand sign", 32'(mn.md), 32'(md_sign_o));
            chk("g sign", 32'(mn.gs), 32'(g_sign_o));
            for (int i = 0; i < 10; i++)
                chk("pulse count", 32'(mn.cn[i]), 32'(cnt[i]));
        end
        rdy_prev = instr_ready_o;
    end

    initial
    begin
        arst_n_i = 1'b0;
        instr_valid_i = 1'b0;
        instr_i = '0;
        cond_i = '0;
        transfer_i = '0;
        void'($urandom(32'h0000_ee88));
        repeat (12) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        for (int i = 0; i < 8; i++)
            issue(5'(`OP_ADD + ($urandom & 1)));
        for (int i = 0; i < 32; i++)
            issue(5'(i));
        for (int i = 0; i < 10; i++)
            issue(tbl[$urandom % 6]);
        for (int k = 0; k < 9000 && q.size() > 0; k++)
            @(posedge clk_i);
        if (q.size() > 0)
            num_errors++;
        final_report();
    end
endmodule : serial_computer_control_unit_test
